// [shared/dfe_pkg.sv]
// Shared constants, register map and ECC helpers for the data flash controller.
package dfe_pkg;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned PROG_TIME_US  = 100;
  localparam int unsigned ERASE_TIME_MS = 15;
  localparam int unsigned PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
  localparam int unsigned ERASE_CYCLES  = ERASE_TIME_MS * 1000 * CLK_MHZ;

  localparam int unsigned NUM_BLOCKS = 128;
  localparam int unsigned BLK_WORDS  = 16;
  localparam int unsigned WORDS      = NUM_BLOCKS * BLK_WORDS;
  localparam int unsigned IDX_W      = $clog2(WORDS);
  localparam int unsigned BLK_SHIFT  = $clog2(BLK_WORDS);
  localparam int unsigned BADDR_W    = IDX_W + 1;

  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_CTRL     = 8'h04;
  localparam logic [7:0] OFS_STAT0    = 8'h08;
  localparam logic [7:0] OFS_STAT1    = 8'h0C;
  localparam logic [7:0] OFS_ADDR     = 8'h10;
  localparam logic [7:0] OFS_INSTR    = 8'h14;
  localparam logic [7:0] OFS_DATA     = 8'h18;
  localparam logic [7:0] OFS_PROT     = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ST   = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  localparam int MODE_EWM  = 0;
  localparam int MODE_RST  = 1;
  localparam int MODE_RDM  = 2;
  localparam int CTRL_ECC  = 0;
  localparam int STAT0_RDY = 0;
  localparam int STAT1_SEQ = 0;
  localparam int STAT1_FIX = 1;
  localparam int PROT_WE   = 0;
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ERR   = 1;
  localparam int IRQ_FIX   = 2;
  localparam int IRQ_W     = 3;

  localparam logic [15:0] CMD_READ  = 16'h00F3;
  localparam logic [15:0] CMD_PROG  = 16'h0041;
  localparam logic [15:0] CMD_ERASE = 16'h0020;
  localparam logic [15:0] CMD_CLEAR = 16'h0050;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {OP_READ = 2'b00, OP_PROG = 2'b01, OP_ERASE = 2'b10} dfe_op_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_BUSY = 2'b01, ST_ABORT = 2'b10} dfe_state_e;

  function automatic logic [3:0] ecc_check(input logic [7:0] d);
    ecc_check = {d[4] ^ d[5] ^ d[6] ^ d[7], d[1] ^ d[2] ^ d[3] ^ d[7],
                 d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6], d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6]};
  endfunction : ecc_check

  // Stored check bits are padded so that an erased word decodes clean.
  localparam logic [3:0] ECC_PAD = 4'hF ^ ecc_check(8'hFF);

  function automatic logic [8:0] ecc_fix(input logic [7:0] d, input logic [3:0] c);
    logic [3:0] s;
    logic [7:0] f;
    s = ecc_check(d) ^ c ^ ECC_PAD;
    case (s)
      4'h3:    f = 8'h01;
      4'h5:    f = 8'h02;
      4'h6:    f = 8'h04;
      4'h7:    f = 8'h08;
      4'h9:    f = 8'h10;
      4'hA:    f = 8'h20;
      4'hB:    f = 8'h40;
      4'hC:    f = 8'h80;
      default: f = 8'h00;
    endcase
    ecc_fix = {s != 4'h0, d ^ f};
  endfunction : ecc_fix
endpackage : dfe_pkg

// [shared/dfe_arr_if.sv]
// Request and answer wires between the command sequencer and the flash array.
`timescale 1ns/1ps
`default_nettype none
interface dfe_arr_if;
  logic                      req;
  logic                      abort;
  dfe_pkg::dfe_op_e          op;
  logic [dfe_pkg::IDX_W-1:0] idx;
  logic [15:0]               wdata;
  logic                      done;
  logic [15:0]               rdata;
  modport seq (output req, abort, op, idx, wdata, input done, rdata);
  modport arr (input req, abort, op, idx, wdata, output done, rdata);
endinterface : dfe_arr_if
`default_nettype wire

// [hdl/dfe_array.sv]
// Flash cell array with timed program and block erase.
`timescale 1ns/1ps
`default_nettype none
module dfe_array #(
  parameter int unsigned PROG_CYCLES  = dfe_pkg::PROG_CYCLES,
  parameter int unsigned ERASE_CYCLES = dfe_pkg::ERASE_CYCLES
) (
  input  wire logic clk,
  input  wire logic resetn,
  dfe_arr_if.arr    port
);
  localparam int unsigned BS = dfe_pkg::BLK_SHIFT;

  // Cells keep their contents over reset, so the array itself has none.
  logic [15:0]               mem [dfe_pkg::WORDS];
  logic                      busy_q;
  dfe_pkg::dfe_op_e          op_q;
  logic [dfe_pkg::IDX_W-1:0] idx_q;
  logic [15:0]               wd_q;
  logic [31:0]               cnt_q;
  logic                      fin;

  assign fin = busy_q && cnt_q == 32'd1 && !port.abort;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      op_q   <= dfe_pkg::OP_READ;
      idx_q  <= '0;
      wd_q   <= '0;
      cnt_q  <= '0;
    end else if (port.abort) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
    end else if (port.req && port.op != dfe_pkg::OP_READ) begin
      busy_q <= 1'b1;
      op_q   <= port.op;
      idx_q  <= port.idx;
      wd_q   <= port.wdata;
      cnt_q  <= (port.op == dfe_pkg::OP_PROG) ? PROG_CYCLES : ERASE_CYCLES;
    end else if (busy_q) begin
      cnt_q  <= cnt_q - 32'd1;
      busy_q <= !fin;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port.done  <= 1'b0;
      port.rdata <= '0;
    end else begin
      port.done <= (port.req && port.op == dfe_pkg::OP_READ && !port.abort) || fin;
      if (port.req && port.op == dfe_pkg::OP_READ) begin
        port.rdata <= mem[port.idx];
      end
    end
  end

  // Programming only clears bits, as a real cell cannot be rewritten to one.
  always_ff @(posedge clk) begin
    if (fin && op_q == dfe_pkg::OP_PROG) begin
      mem[idx_q] <= mem[idx_q] & wd_q;
    end else if (fin && op_q == dfe_pkg::OP_ERASE) begin
      for (int i = 0; i < dfe_pkg::BLK_WORDS; i++) begin
        mem[{idx_q[dfe_pkg::IDX_W-1:BS], BS'(i)}] <= 16'hFFFF;
      end
    end
  end
endmodule : dfe_array
`default_nettype wire

// [hdl/dfe_ctrl.sv]
// Data flash controller top: register slave, command sequencer and ECC.
// How it works
// RULE1 - Raw mode: 128 blocks of 32 bytes.
// RULE2 - ECC mode: 128 blocks of 16 bytes.
// RULE3 - Program unit: 2 bytes raw, 1 byte ECC.
// RULE4 - One erase command clears exactly one block.
// RULE5 - Only software commands start program or erase.
// RULE6 - Commands: read, program, erase, clear status.
// RULE7 - ECC mode corrects any single-bit read error.
// RULE8 - Operations run in background, CPU keeps going.
// RULE9 - Array reached only via address, instruction, data.
// RULE10 - Mode register writable only with protect bit set.
// RULE11 - Module reset aborts work, keeps register contents.
// RULE12 - Software clears reset bit after ready reads one.
// RULE13 - No module reset during regulator stop or rewrite.
// RULE14 - In read mode, writes force the read command.
// RULE15 - No program enable during main flash rewrite.
// RULE16 - No main flash rewrite while program enabled.
// RULE17 - Ready low while busy, high when idle.
// RULE18 - Program enable clear blocks program and erase.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dfe_ctrl #(
  parameter int unsigned ADDR_W       = 8,
  parameter int unsigned PROG_CYCLES  = dfe_pkg::PROG_CYCLES,
  parameter int unsigned ERASE_CYCLES = dfe_pkg::ERASE_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   irq
);
  localparam int unsigned BS = dfe_pkg::BLK_SHIFT;
  localparam int unsigned IW = dfe_pkg::IDX_W;
  localparam int unsigned AW = dfe_pkg::BADDR_W;
  dfe_arr_if arr ();
  logic                     aw_got_q, w_got_q;
  logic [ADDR_W-1:0]        waddr_q;
  logic [31:0]              wdat_q;
  logic [3:0]               wstrb_q;
  logic                     ewm_q, mreset_q, rdmode_q, ecc_en_q, prot_we_q;
  logic [AW-1:0]            addr_q;
  logic [15:0]              instr_q, data_q;
  logic                     seq_err_q, fix_q;
  logic [dfe_pkg::IRQ_W-1:0] irq_st_q, irq_mask_q, ev, w1c;
  dfe_pkg::dfe_state_e      st_q;
  logic [32:0]              rcur, rd_a;
  logic [31:0]              wmask, wval;
  logic                     wfire, mode_wr, go, start, refused, rd_done;
  logic [15:0]              go_cmd;
  logic [AW-1:0]            go_addr;
  logic [IW-1:0]            go_idx;
  logic [8:0]               fixv;
  function automatic logic [ADDR_W-1:0] ofs(input logic [7:0] o);
    ofs = ADDR_W'(o);
  endfunction : ofs
  // Bit 32 of the result marks an unmapped address.
  function automatic logic [32:0] reg_rd(input logic [ADDR_W-1:0] a);
    reg_rd = '0;
    case (a)
      ofs(dfe_pkg::OFS_MODE): begin
        reg_rd[dfe_pkg::MODE_EWM] = ewm_q;
        reg_rd[dfe_pkg::MODE_RST] = mreset_q;
        reg_rd[dfe_pkg::MODE_RDM] = rdmode_q;
      end
      ofs(dfe_pkg::OFS_CTRL):     reg_rd[dfe_pkg::CTRL_ECC] = ecc_en_q;
      ofs(dfe_pkg::OFS_STAT0):    reg_rd[dfe_pkg::STAT0_RDY] = st_q == dfe_pkg::ST_IDLE; // see RULE17
      ofs(dfe_pkg::OFS_STAT1): begin
        reg_rd[dfe_pkg::STAT1_SEQ] = seq_err_q;
        reg_rd[dfe_pkg::STAT1_FIX] = fix_q;
      end
      ofs(dfe_pkg::OFS_ADDR):     reg_rd[AW-1:0] = addr_q;
      ofs(dfe_pkg::OFS_INSTR):    reg_rd[15:0] = instr_q;
      ofs(dfe_pkg::OFS_DATA):     reg_rd[15:0] = data_q;
      ofs(dfe_pkg::OFS_PROT):     reg_rd[dfe_pkg::PROT_WE] = prot_we_q;
      ofs(dfe_pkg::OFS_IRQ_ST):   reg_rd[dfe_pkg::IRQ_W-1:0] = irq_st_q;
      ofs(dfe_pkg::OFS_IRQ_MASK): reg_rd[dfe_pkg::IRQ_W-1:0] = irq_mask_q;
      default:                    reg_rd[32] = 1'b1;
    endcase
  endfunction : reg_rd

  always_comb begin
    rcur    = reg_rd(waddr_q);
    rd_a    = reg_rd(araddr);
    wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wval    = (rcur[31:0] & ~wmask) | (wdat_q & wmask);
    wfire   = aw_got_q && w_got_q && !bvalid;
    mode_wr = wfire && waddr_q == ofs(dfe_pkg::OFS_MODE) && prot_we_q;
    // The array is reached only through these three registers.
    go      = wfire && (waddr_q == ofs(dfe_pkg::OFS_INSTR) || (rdmode_q && // see RULE9
              (waddr_q == ofs(dfe_pkg::OFS_ADDR) || waddr_q == ofs(dfe_pkg::OFS_DATA))));
    go_cmd  = rdmode_q ? dfe_pkg::CMD_READ : wval[15:0]; // see RULE14
    go_addr = (waddr_q == ofs(dfe_pkg::OFS_ADDR)) ? wval[AW-1:0] : addr_q;
    // Raw mode addresses 16-bit words, ECC mode one byte per stored word.
    go_idx  = ecc_en_q ? go_addr[IW-1:0] : go_addr[AW-1:1]; // see RULE1, RULE2
    start   = go && st_q == dfe_pkg::ST_IDLE && !mreset_q &&
              (go_cmd == dfe_pkg::CMD_READ ||
               (ewm_q && (go_cmd == dfe_pkg::CMD_PROG || go_cmd == dfe_pkg::CMD_ERASE))); // see RULE18
    refused = go && !start && !mreset_q &&
              !(st_q == dfe_pkg::ST_IDLE && go_cmd == dfe_pkg::CMD_CLEAR);
    rd_done = st_q == dfe_pkg::ST_BUSY && arr.done && arr.op == dfe_pkg::OP_READ;
    fixv    = dfe_pkg::ecc_fix(arr.rdata[7:0], arr.rdata[11:8]);
    ev                    = '0;
    ev[dfe_pkg::IRQ_DONE] = st_q == dfe_pkg::ST_BUSY && arr.done;
    ev[dfe_pkg::IRQ_ERR]  = refused;
    ev[dfe_pkg::IRQ_FIX]  = rd_done && ecc_en_q && fixv[8];
    w1c = (wfire && waddr_q == ofs(dfe_pkg::OFS_IRQ_ST)) ?
          wdat_q[dfe_pkg::IRQ_W-1:0] & wmask[dfe_pkg::IRQ_W-1:0] : '0;
  end

  // Address and data are taken in either order; the write lands once both are in.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= dfe_pkg::RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      waddr_q  <= '0;
      wdat_q   <= '0;
      wstrb_q  <= '0;
    end else begin
      bvalid <= bvalid && !bready;
      if (wfire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        awready  <= 1'b1;
        wready   <= 1'b1;
        bvalid   <= 1'b1;
        bresp    <= rcur[32] ? dfe_pkg::RESP_SLVERR : dfe_pkg::RESP_OKAY;
      end else begin
        if (awvalid && awready) begin
          aw_got_q <= 1'b1;
          waddr_q  <= awaddr;
          awready  <= 1'b0;
        end else if (!aw_got_q) begin
          awready <= 1'b1;
        end
        if (wvalid && wready) begin
          w_got_q <= 1'b1;
          wdat_q  <= wdata;
          wstrb_q <= wstrb;
          wready  <= 1'b0;
        end else if (!w_got_q) begin
          wready <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= dfe_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_a[31:0];
      rresp   <= rd_a[32] ? dfe_pkg::RESP_SLVERR : dfe_pkg::RESP_OKAY;
    end else if (!rvalid || rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ewm_q      <= 1'b0;
      mreset_q   <= 1'b0;
      rdmode_q   <= 1'b0;
      ecc_en_q   <= 1'b0;
      prot_we_q  <= 1'b0;
      addr_q     <= '0;
      instr_q    <= '0;
      data_q     <= '0;
      irq_mask_q <= '0;
    end else begin
      if (mode_wr) begin // see RULE10
        ewm_q    <= wval[dfe_pkg::MODE_EWM];
        mreset_q <= wval[dfe_pkg::MODE_RST];
        rdmode_q <= wval[dfe_pkg::MODE_RDM];
      end
      // Switching ECC mid-operation would change the address map under the array.
      if (wfire && waddr_q == ofs(dfe_pkg::OFS_CTRL) && st_q == dfe_pkg::ST_IDLE) begin
        ecc_en_q <= wval[dfe_pkg::CTRL_ECC];
      end
      if (wfire) begin
        case (waddr_q)
          ofs(dfe_pkg::OFS_ADDR):     addr_q     <= wval[AW-1:0];
          ofs(dfe_pkg::OFS_DATA):     data_q     <= wval[15:0];
          ofs(dfe_pkg::OFS_PROT):     prot_we_q  <= wval[dfe_pkg::PROT_WE];
          ofs(dfe_pkg::OFS_IRQ_MASK): irq_mask_q <= wval[dfe_pkg::IRQ_W-1:0];
          default:                    ;
        endcase
      end
      if (go) begin
        instr_q <= go_cmd; // see RULE14
      end
      if (rd_done) begin
        data_q <= ecc_en_q ? {8'h00, fixv[7:0]} : arr.rdata; // see RULE7
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q      <= dfe_pkg::ST_IDLE;
      arr.req   <= 1'b0;
      arr.abort <= 1'b0;
      arr.op    <= dfe_pkg::OP_READ;
      arr.idx   <= '0;
      arr.wdata <= '0;
      seq_err_q <= 1'b0;
      fix_q     <= 1'b0;
    end else begin
      arr.req   <= 1'b0;
      arr.abort <= 1'b0;
      seq_err_q <= seq_err_q | refused;
      fix_q     <= fix_q | ev[dfe_pkg::IRQ_FIX];
      if (mode_wr && wval[dfe_pkg::MODE_RST]) begin
        arr.abort <= 1'b1; // see RULE11
        st_q      <= dfe_pkg::ST_ABORT;
      end else begin
        case (st_q)
          dfe_pkg::ST_IDLE: begin
            if (go && !mreset_q && go_cmd == dfe_pkg::CMD_CLEAR) begin
              seq_err_q <= 1'b0;
              fix_q     <= 1'b0;
            end
            if (start) begin // see RULE5, RULE6
              st_q    <= dfe_pkg::ST_BUSY;
              arr.req <= 1'b1;
              arr.idx <= go_idx;
              case (go_cmd)
                dfe_pkg::CMD_PROG: begin
                  arr.op    <= dfe_pkg::OP_PROG;
                  arr.wdata <= ecc_en_q ? {4'hF, dfe_pkg::ecc_check(data_q[7:0]) ^ // see RULE3
                               dfe_pkg::ECC_PAD, data_q[7:0]} : data_q;
                end
                dfe_pkg::CMD_ERASE: begin
                  arr.op  <= dfe_pkg::OP_ERASE;
                  arr.idx <= {go_idx[IW-1:BS], BS'(0)}; // see RULE4
                end
                default: arr.op <= dfe_pkg::OP_READ;
              endcase
            end
          end
          dfe_pkg::ST_BUSY: begin
            if (arr.done) begin
              st_q <= dfe_pkg::ST_IDLE; // see RULE8
            end
          end
          default: st_q <= dfe_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // The output lags the status by one cycle so that it comes from a flop.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_st_q <= '0;
      irq      <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~w1c) | ev;
      irq      <= |(irq_st_q & irq_mask_q);
    end
  end
  dfe_array #(
    .PROG_CYCLES  (PROG_CYCLES),
    .ERASE_CYCLES (ERASE_CYCLES)
  ) u_array (
    .clk    (clk),
    .resetn (resetn),
    .port   (arr.arr)
  );
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  raw_index_a: assert property ( // see RULE1
    arr.req && !ecc_en_q && arr.op == dfe_pkg::OP_READ |-> arr.idx == $past(go_addr[AW-1:1]))
    else $error("raw read index is not the word address");
  ecc_index_a: assert property ( // see RULE2
    arr.req && ecc_en_q && arr.op == dfe_pkg::OP_READ |-> arr.idx == $past(go_addr[IW-1:0]))
    else $error("ecc read index is not the byte address");
  prog_unit_a: assert property ( // see RULE3
    arr.req && arr.op == dfe_pkg::OP_PROG |->
      arr.wdata == ($past(ecc_en_q) ? {4'hF, dfe_pkg::ecc_check($past(data_q[7:0])) ^
      dfe_pkg::ECC_PAD, $past(data_q[7:0])} : $past(data_q)))
    else $error("program word does not match the data register");
  erase_block_a: assert property ( // see RULE4
    arr.req && arr.op == dfe_pkg::OP_ERASE |-> arr.idx[BS-1:0] == '0)
    else $error("erase not aligned to one block");
  sw_start_a: assert property ( // see RULE5
    arr.req && arr.op != dfe_pkg::OP_READ |-> $past(wfire && waddr_q == ofs(dfe_pkg::OFS_INSTR)))
    else $error("program or erase started without a command write");
  prog_gate_a: assert property ( // see RULE18
    arr.req && arr.op != dfe_pkg::OP_READ |-> $past(ewm_q))
    else $error("program or erase started while disabled");
  ecc_fix_a: assert property ( // see RULE7
    rd_done && ecc_en_q |=> data_q == {8'h00, $past(fixv[7:0])})
    else $error("corrected byte not delivered");
  abort_seq_a: assert property ( // see RULE11
    mode_wr && wval[dfe_pkg::MODE_RST] |=> arr.abort && st_q == dfe_pkg::ST_ABORT
      ##1 st_q == dfe_pkg::ST_IDLE && $stable(addr_q))
    else $error("module reset did not return to idle");
  force_read_a: assert property ( // see RULE14
    go && rdmode_q |=> instr_q == dfe_pkg::CMD_READ)
    else $error("read mode write did not force the read command");
  read_time_a: assert property ( // see RULE17
    start && go_cmd == dfe_pkg::CMD_READ |=> st_q == dfe_pkg::ST_BUSY ##2 st_q == dfe_pkg::ST_IDLE)
    else $error("read did not finish in two cycles");
  irq_out_a: assert property (
    |(irq_st_q & irq_mask_q) |=> irq)
    else $error("pending unmasked event without interrupt");
  prog_done_c: cover property (arr.op == dfe_pkg::OP_PROG && ev[dfe_pkg::IRQ_DONE]);
  erase_done_c: cover property (arr.op == dfe_pkg::OP_ERASE && ev[dfe_pkg::IRQ_DONE]);
  ecc_fix_c: cover property (ev[dfe_pkg::IRQ_FIX]);
  abort_busy_c: cover property (st_q == dfe_pkg::ST_BUSY && mode_wr && wval[dfe_pkg::MODE_RST]);
endmodule : dfe_ctrl
`default_nettype wire

// [verification/dfe_tb.sv]
// Self-checking testbench for the data flash controller.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} dfe_row_s;
  logic        clk, resetn, awvalid, wvalid, arvalid, awready, wready, bvalid;
  logic        arready, rvalid, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, q;
  logic [1:0]  bresp, rresp, resp;
  int          bad_count, comparisons;
  dfe_row_s    rows [5];

  // Short program and erase times keep the run brief; erase stays long enough to abort.
  dfe_ctrl #(.PROG_CYCLES(4), .ERASE_CYCLES(20)) i_dut (
    .clk(clk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
    .irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test;
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 300) begin
      bad_count++;
      stop_test();
    end
  endtask : tick

  // Each transfer starts one edge late so no valid is driven twice in one time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic ad, wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      tick(n);
      if (awready === 1'b1 && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do tick(n); while (bvalid !== 1'b1);
    resp = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do tick(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do tick(n); while (rvalid !== 1'b1);
    q = rdata;
    resp = rresp;
  endtask : rd

  task automatic waitrdy;
    int n;
    n = 0;
    do begin
      rd(dfe_pkg::OFS_STAT0);
      tick(n);
    end while (q[0] !== 1'b1);
  endtask : waitrdy

  task automatic cmd(input logic [15:0] c);
    wr(dfe_pkg::OFS_INSTR, {16'h0, c});
    waitrdy();
  endtask : cmd

  task automatic prog(input logic [7:0] a, input logic [31:0] d);
    wr(dfe_pkg::OFS_ADDR, {24'h0, a});
    wr(dfe_pkg::OFS_DATA, d);
    cmd(dfe_pkg::CMD_PROG);
  endtask : prog

  task automatic rdarr(input logic [7:0] a, input logic [31:0] e);
    wr(dfe_pkg::OFS_ADDR, {24'h0, a});
    cmd(dfe_pkg::CMD_READ);
    rd(dfe_pkg::OFS_DATA);
    chk(q, e);
  endtask : rdarr

  initial begin
    resetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    rows = '{'{dfe_pkg::OFS_PROT, 32'h1, 32'h1}, '{dfe_pkg::OFS_ADDR, 32'hFFFFFABC, 32'hABC},
             '{dfe_pkg::OFS_DATA, 32'h12345678, 32'h5678},
             '{dfe_pkg::OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h7},
             '{dfe_pkg::OFS_STAT0, 32'h0, 32'h1}};
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(dfe_pkg::OFS_STAT0);
    chk(q, 32'h1);
    wr(dfe_pkg::OFS_MODE, 32'h1);
    rd(dfe_pkg::OFS_MODE);
    chk(q, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(q, rows[i].e);
    end
    wr(8'h40, 32'h1);
    chk({30'h0, resp}, {30'h0, dfe_pkg::RESP_SLVERR});
    rd(8'h40);
    chk({resp, q[29:0]}, {dfe_pkg::RESP_SLVERR, 30'h0});
    cmd(dfe_pkg::CMD_PROG);
    rd(dfe_pkg::OFS_STAT1);
    chk(q, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(dfe_pkg::OFS_IRQ_MASK, 32'h0);
    rd(dfe_pkg::OFS_IRQ_ST);
    chk({30'h0, irq, q[1]}, 32'h1);
    wr(dfe_pkg::OFS_IRQ_ST, 32'h7);
    wr(dfe_pkg::OFS_IRQ_MASK, 32'h7);
    rd(dfe_pkg::OFS_IRQ_ST);
    chk({q[31:1], irq}, 32'h0);
    cmd(dfe_pkg::CMD_CLEAR);
    rd(dfe_pkg::OFS_STAT1);
    chk(q, 32'h0);
    // The bench has no main flash or regulator, so neither is ever busy or stopped here.
    wr(dfe_pkg::OFS_MODE, 32'h1);
    wr(dfe_pkg::OFS_ADDR, 32'h60);
    cmd(dfe_pkg::CMD_ERASE);
    prog(8'h60, 32'hAA);
    wr(dfe_pkg::OFS_ADDR, 32'h40);
    wr(dfe_pkg::OFS_INSTR, {16'h0, dfe_pkg::CMD_ERASE});
    rd(dfe_pkg::OFS_STAT0);
    chk(q, 32'h0);
    wr(dfe_pkg::OFS_INSTR, {16'h0, dfe_pkg::CMD_READ});
    waitrdy();
    rd(dfe_pkg::OFS_STAT1);
    chk(q, 32'h1);
    rdarr(8'h60, 32'hAA);
    rdarr(8'h5E, 32'hFFFF);
    prog(8'h40, 32'hFFFE);
    rdarr(8'h40, 32'hFFFE);
    rdarr(8'h42, 32'hFFFF);
    cmd(dfe_pkg::CMD_CLEAR);
    wr(dfe_pkg::OFS_CTRL, 32'h1);
    // The raw word above has one data bit cleared, so the byte must come back repaired.
    rdarr(8'h20, 32'hFF);
    rd(dfe_pkg::OFS_STAT1);
    chk(q, 32'h2);
    prog(8'h21, 32'h5A);
    rdarr(8'h21, 32'h5A);
    rdarr(8'h22, 32'hFF);
    wr(dfe_pkg::OFS_MODE, 32'h5);
    wr(dfe_pkg::OFS_ADDR, 32'h21);
    rd(dfe_pkg::OFS_INSTR);
    chk(q, 32'hF3);
    waitrdy();
    rd(dfe_pkg::OFS_DATA);
    chk(q, 32'h5A);
    wr(dfe_pkg::OFS_MODE, 32'h1);
    wr(dfe_pkg::OFS_INSTR, {16'h0, dfe_pkg::CMD_ERASE});
    wr(dfe_pkg::OFS_MODE, 32'h3);
    rd(dfe_pkg::OFS_STAT0);
    chk(q, 32'h1);
    wr(dfe_pkg::OFS_MODE, 32'h1);
    rd(dfe_pkg::OFS_ADDR);
    chk(q, 32'h21);
    // A second reset in mid-run must close the mode register again.
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    wr(dfe_pkg::OFS_MODE, 32'h1);
    rd(dfe_pkg::OFS_MODE);
    chk(q, 32'h0);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
